// ===== logic/flash_block_lock_cfg.svh
// Constants for the flash block lock controller
`ifndef FLASH_BLOCK_LOCK_CFG_SVH
`define FLASH_BLOCK_LOCK_CFG_SVH

`define NUM_BLOCKS      16
`define BLK_W           4
`define ADDR_W          8
`define BLK_MSB         7
`define BLK_LSB         4
`define OFS_MSB         3
`define OFS_W           4
`define OTP_WORDS       4
`define OTP_SEL_W       2

`define OFS_LOCK_STATE  4'h2
`define CODE_LOCK_SETUP 8'h60
`define CODE_LOCK       8'h01
`define CODE_UNLOCK     8'hD0
`define CODE_LOCKDOWN   8'h2F
`define CODE_READ_ID    8'h90
`define CODE_READ_ARRAY 8'hFF

`define LOCK_RESET      16'hFFFF
`define DOWN_RESET      16'h0000
`define OTP_ERASED      64'hFFFF_FFFF_FFFF_FFFF
// Arbitrary neutral factory value
`define OTP_FACTORY     64'h0123_4567_89AB_CDEF

`endif

// ===== logic/flash_block_lock_pkg.sv
// Types for the flash block lock controller
`default_nettype none
package flash_block_lock_pkg;

  typedef struct packed {
    logic wsm_ready;
    logic erase_suspended;
    logic erase_err;
    logic program_err;
    logic vpp_err;
    logic program_suspended;
    logic locked_block_err;
    logic reserved;
  } status_flags_t;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef enum logic [0:0] {
    CMD_IDLE,
    CMD_LOCK_SETUP
  } cmd_state_t;

endpackage
`default_nettype wire

// ===== logic/flash_block_lock_control.sv
// Per-block lock, lock-down and OTP protection logic of a partitioned NOR flash
`include "flash_block_lock_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_block_lock_control (
  // Clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  // Host bus
  input  wire flash_block_lock_pkg::bus_req_t bus_i,
  output logic [15:0]                         rdata_o,
  // Pins and engine status
  input  wire logic                           wp_n_i,
  input  wire logic                           vpp_low_i,
  input  wire logic                           wsm_ready_i,
  input  wire logic                           erase_suspended_i,
  input  wire logic                           program_suspended_i,
  input  wire logic                           status_clear_i,
  output flash_block_lock_pkg::status_flags_t status_flags_o,
  // Program and erase check
  input  wire logic                           pe_req_i,
  input  wire logic [`BLK_W-1:0]              pe_block_i,
  output logic                                pe_go_o,
  output logic                                pe_refused_o,
  // Protection register
  input  wire logic                           otp_prog_i,
  input  wire logic [`OTP_SEL_W-1:0]          otp_sel_i,
  input  wire logic [15:0]                    otp_data_i,
  input  wire logic                           otp_lock_i,
  output logic [127:0]                        otp_value_o,
  output logic                                otp_locked_o
);
  import flash_block_lock_pkg::*;

  cmd_state_t            state_ff;
  logic [`NUM_BLOCKS-1:0] lock_ff;
  logic [`NUM_BLOCKS-1:0] down_ff;
  logic [`NUM_BLOCKS-1:0] eff_lock;
  logic                  id_mode_ff;
  logic                  err5_ff;
  logic                  err4_ff;
  logic                  err3_ff;
  logic                  err1_ff;
  logic [63:0]           user_ff;
  logic                  otp_lock_ff;
  logic                  wp_asserted;
  logic [`BLK_W-1:0]     cmd_blk;
  logic [`OFS_W-1:0]     cmd_ofs;
  logic [7:0]            code;
  logic                  second_cycle;
  logic                  code_ok;
  logic                  protected_blk;
  logic                  lock_apply;
  logic                  otp_bad;
  logic [63:0]           otp_mask;
  logic [63:0]           nxt_user;

  assign wp_asserted   = ~wp_n_i;
  assign cmd_blk       = bus_i.addr[`BLK_MSB:`BLK_LSB];
  assign cmd_ofs       = bus_i.addr[`OFS_MSB:0];
  assign code          = bus_i.wdata[7:0];
  assign second_cycle  = bus_i.wr_en && (state_ff == CMD_LOCK_SETUP);
  assign code_ok       = (code == `CODE_LOCK) || (code == `CODE_UNLOCK) ||
                         (code == `CODE_LOCKDOWN);
  // Hard lock-down: write-protect only bites where lock-down was set
  assign protected_blk = down_ff[cmd_blk] && wp_asserted;
  // Program supply level is not consulted here on purpose
  assign lock_apply    = second_cycle && code_ok && !protected_blk &&
                         !program_suspended_i;
  assign eff_lock      = lock_ff | (down_ff & {`NUM_BLOCKS{wp_asserted}});

  // Command sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= CMD_IDLE;
    end else if (bus_i.wr_en) begin
      unique case (state_ff)
        CMD_IDLE:       state_ff <= (code == `CODE_LOCK_SETUP) ? CMD_LOCK_SETUP : CMD_IDLE;
        CMD_LOCK_SETUP: state_ff <= CMD_IDLE;
      endcase
    end
  end

  // Identifier versus array read mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      id_mode_ff <= 1'b0;
    end else if (bus_i.wr_en && state_ff == CMD_IDLE) begin
      if (code == `CODE_READ_ID) begin
        id_mode_ff <= 1'b1;
      end else if (code == `CODE_READ_ARRAY) begin
        id_mode_ff <= 1'b0;
      end
    end
  end

  // Lock bits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= `LOCK_RESET;
    end else begin
      // Asserted write-protect pins locked-down blocks at state 011, so release leaves 111
      if (wp_asserted) begin
        lock_ff <= lock_ff | down_ff;
      end
      if (lock_apply) begin
        if (code == `CODE_UNLOCK) begin
          lock_ff[cmd_blk] <= 1'b0;
        end else begin
          lock_ff[cmd_blk] <= 1'b1;
        end
      end
    end
  end

  // Lock-down bits: only reset clears them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      down_ff <= `DOWN_RESET;
    end else if (lock_apply && code == `CODE_LOCKDOWN) begin
      down_ff[cmd_blk] <= 1'b1;
    end
  end

  // Read data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (bus_i.rd_en) begin
      if (id_mode_ff && cmd_ofs == `OFS_LOCK_STATE) begin
        rdata_o <= {14'h0000, down_ff[cmd_blk], eff_lock[cmd_blk]};
      end else begin
        rdata_o <= 16'h0000;
      end
    end
  end

  // Program and erase gate; grant is combinational as a handshake
  assign pe_refused_o = pe_req_i && (eff_lock[pe_block_i] || vpp_low_i);
  assign pe_go_o      = pe_req_i && !eff_lock[pe_block_i] && !vpp_low_i;

  // Sticky error flags: a new error in the clear cycle survives
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err5_ff <= 1'b0;
      err4_ff <= 1'b0;
    end else begin
      err5_ff <= (err5_ff && !status_clear_i) ||
                 (second_cycle && !code_ok) || (otp_prog_i && otp_lock_ff);
      err4_ff <= (err4_ff && !status_clear_i) ||
                 (second_cycle && !code_ok) || otp_bad;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err3_ff <= 1'b0;
      err1_ff <= 1'b0;
    end else begin
      err3_ff <= (err3_ff && !status_clear_i) || (pe_req_i && vpp_low_i);
      err1_ff <= (err1_ff && !status_clear_i) || (pe_req_i && eff_lock[pe_block_i]);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_flags_o <= '0;
    end else begin
      status_flags_o.wsm_ready         <= wsm_ready_i;
      status_flags_o.erase_suspended   <= erase_suspended_i;
      status_flags_o.erase_err         <= err5_ff;
      status_flags_o.program_err       <= err4_ff;
      status_flags_o.vpp_err           <= err3_ff;
      status_flags_o.program_suspended <= program_suspended_i;
      status_flags_o.locked_block_err  <= err1_ff;
      status_flags_o.reserved          <= 1'b0;
    end
  end

  // Protection register: user half is AND-only, so bits can fall but never rise
  assign otp_bad  = otp_prog_i && otp_lock_ff;
  // Shift the zeros, not the ones, so words outside the selected one stay all ones
  assign otp_mask = ~({48'h0000_0000_0000, ~otp_data_i} << {otp_sel_i, 4'h0});
  assign nxt_user = user_ff & otp_mask;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      user_ff <= `OTP_ERASED;
    end else if (otp_prog_i && !otp_lock_ff) begin
      user_ff <= nxt_user;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_lock_ff <= 1'b0;
    end else if (otp_lock_i) begin
      otp_lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_value_o  <= {`OTP_ERASED, `OTP_FACTORY};
      otp_locked_o <= 1'b0;
    end else begin
      otp_value_o  <= {user_ff, `OTP_FACTORY};
      otp_locked_o <= otp_lock_ff;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_refuse_locked;
    pe_req_i && (lock_ff[pe_block_i] || (down_ff[pe_block_i] && !wp_n_i)) |-> !pe_go_o ##2
      status_flags_o.locked_block_err;
  endproperty
  a_refuse_locked: assert property (p_refuse_locked) else $error("locked block not refused");

  property p_unlock_blocked;
    second_cycle && code == `CODE_UNLOCK && protected_blk |=> lock_ff[$past(cmd_blk)];
  endproperty
  a_unlock_blocked: assert property (p_unlock_blocked) else $error("hard lock-down unlocked");

  property p_unlock_works;
    second_cycle && code == `CODE_UNLOCK && !down_ff[cmd_blk] && !program_suspended_i
      && !wp_asserted |=> !lock_ff[$past(cmd_blk)];
  endproperty
  a_unlock_works: assert property (p_unlock_works) else $error("unlock lost");

  property p_down_sticky;
    ($past(down_ff) & ~down_ff) == `DOWN_RESET;
  endproperty
  a_down_sticky: assert property (p_down_sticky) else $error("lock-down bit cleared");

  property p_free_block_go;
    pe_req_i && !lock_ff[pe_block_i] && !down_ff[pe_block_i] && !vpp_low_i |-> pe_go_o;
  endproperty
  a_free_block_go: assert property (p_free_block_go) else $error("write-protect hit free block");

  property p_bad_code;
    second_cycle && !code_ok |-> ##2 status_flags_o.erase_err && status_flags_o.program_err;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("sequence error not flagged");

  property p_err_sticky;
    status_flags_o.erase_err && !status_clear_i && !$past(status_clear_i) |=>
      status_flags_o.erase_err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error bit dropped");

  property p_prog_susp;
    second_cycle && program_suspended_i |=> lock_ff[$past(cmd_blk)] ==
      $past(lock_ff[cmd_blk]) && down_ff == $past(down_ff);
  endproperty
  a_prog_susp: assert property (p_prog_susp) else $error("lock change in program suspend");

  property p_lockdown_sets;
    lock_apply && code == `CODE_LOCKDOWN |=> lock_ff[$past(cmd_blk)] && down_ff[$past(cmd_blk)];
  endproperty
  a_lockdown_sets: assert property (p_lockdown_sets) else $error("lock-down incomplete");

  property p_id_read;
    bus_i.rd_en && id_mode_ff && cmd_ofs == `OFS_LOCK_STATE |=>
      rdata_o[1] == $past(down_ff[cmd_blk]) && rdata_o[15:2] == 14'h0000;
  endproperty
  a_id_read: assert property (p_id_read) else $error("lock state read wrong");

  property p_otp_one_way;
    (user_ff & ~$past(user_ff)) == 64'h0000_0000_0000_0000;
  endproperty
  a_otp_one_way: assert property (p_otp_one_way) else $error("OTP bit rose");

  property p_otp_locked;
    otp_lock_ff |=> user_ff == $past(user_ff);
  endproperty
  a_otp_locked: assert property (p_otp_locked) else $error("locked OTP changed");

  property p_lock_bit_read;
    bus_i.rd_en && id_mode_ff && cmd_ofs == `OFS_LOCK_STATE |=>
      rdata_o[0] == $past(lock_ff[cmd_blk] || (down_ff[cmd_blk] && !wp_n_i));
  endproperty
  a_lock_bit_read: assert property (p_lock_bit_read) else $error("lock bit read wrong");

  // Lock bits of lock-down blocks must be set one cycle after write-protect is seen low
  property p_wp_forces_lock;
    !wp_n_i |=> (lock_ff & $past(down_ff)) == $past(down_ff);
  endproperty
  a_wp_forces_lock: assert property (p_wp_forces_lock) else $error("lock-down not held");

  property p_lock_sets;
    lock_apply && code == `CODE_LOCK |=> lock_ff[$past(cmd_blk)];
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock command lost");

  property p_pe_one_answer;
    pe_req_i |-> pe_go_o != pe_refused_o;
  endproperty
  a_pe_one_answer: assert property (p_pe_one_answer) else $error("pe answer clash");

  property p_supply_refuse;
    pe_req_i && vpp_low_i |-> pe_refused_o ##2 status_flags_o.vpp_err;
  endproperty
  a_supply_refuse: assert property (p_supply_refuse) else $error("low supply not refused");

  property p_otp_locked_err;
    otp_prog_i && otp_lock_ff |-> ##2 status_flags_o.erase_err && status_flags_o.program_err;
  endproperty
  a_otp_locked_err: assert property (p_otp_locked_err) else $error("OTP lock error lost");

  c_lockdown: cover property (lock_apply && code == `CODE_LOCKDOWN ##[1:20] wp_asserted);
  c_refuse: cover property (pe_refused_o && wp_asserted);
  c_bad_code: cover property (second_cycle && !code_ok);
  c_susp_lock: cover property (lock_apply && erase_suspended_i);
  c_otp_refused: cover property (otp_prog_i && otp_lock_ff);

endmodule

`default_nettype wire

// ===== bench/flash_host_model.sv
// Host side bus model that issues lock and identifier commands
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // Clock
  input  wire logic                          sys_clk_i,
  // Bus to the device
  output var flash_block_lock_pkg::bus_req_t bus_o
);
  import flash_block_lock_pkg::*;
  initial bus_o = '0;
  // Released strobes drop to zero and address and data show inverted values so stale data never looks valid
  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    bus_o = {w, ~w, a, 8'h00, d};
    @(negedge sys_clk_i);
    bus_o = {2'b00, ~bus_o.addr, ~bus_o.wdata};
  endtask
  task automatic lock_cmd(input logic [3:0] b, input logic [7:0] c);
    go(1'b1, {b, 4'h0}, 8'h60);
    go(1'b1, {b, 4'h0}, c);
  endtask
  task automatic id_rd(input logic [3:0] b, input logic [3:0] o);
    go(1'b1, {b, 4'h0}, 8'h90);
    go(1'b0, {b, o}, 8'h00);
    go(1'b1, {b, 4'h0}, 8'hFF);
  endtask
endmodule
`default_nettype wire

// ===== bench/flash_block_lock_control_tb_top.sv
// Self-checking testbench for the block lock controller
`timescale 1ns/1ps
`default_nettype none
module flash_block_lock_control_tb_top;
  import flash_block_lock_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          wp_n = 1'b1;
  logic          vpp_low = 1'b0;
  logic          esus = 1'b0;
  logic          psus = 1'b0;
  logic          sclr = 1'b0;
  logic          pe_req = 1'b0;
  logic [3:0]    pe_blk = 4'h0;
  logic          otp_prog = 1'b0;
  logic          otp_lock = 1'b0;
  logic [1:0]    otp_sel = 2'h0;
  logic [15:0]   otp_d = 16'h0000;
  bus_req_t      bus;
  status_flags_t st;
  logic [15:0]   rdata;
  logic          grant;
  logic          refused;
  logic [127:0]  otp_val;
  logic          otp_lk;
  logic [15:0]   rq[$];
  logic [3:0]    blk;
  logic [15:0]   d;
  int            errors = 0;
  int            tests_run = 0;
  int            seed = 81;

  flash_block_lock_control flash_block_lock_control_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .wp_n_i(wp_n), .vpp_low_i(vpp_low), .wsm_ready_i(1'b1),
    .erase_suspended_i(esus), .program_suspended_i(psus), .status_clear_i(sclr),
    .status_flags_o(st), .pe_req_i(pe_req), .pe_block_i(pe_blk), .pe_go_o(grant),
    .pe_refused_o(refused), .otp_prog_i(otp_prog), .otp_sel_i(otp_sel),
    .otp_data_i(otp_d), .otp_lock_i(otp_lock), .otp_value_o(otp_val),
    .otp_locked_o(otp_lk));
  flash_host_model flash_host_model_i (.sys_clk_i(sys_clk_i), .bus_o(bus));

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read data lands on the edge that takes the strobe and is checked at the next falling edge
  always @(posedge sys_clk_i) begin
    if (bus.rd_en === 1'b1) begin
      @(negedge sys_clk_i);
      chk("rdata", rq.size() > 0 ? rq.pop_front() : 16'hDEAD, rdata);
    end
  end
  task automatic ls(input logic [3:0] b, input logic [1:0] e, input logic [3:0] o = 4'h2);
    rq.push_back({14'h0000, e});
    flash_host_model_i.id_rd(b, o);
  endtask
  task automatic stc(input logic [7:0] e);
    repeat (2) @(negedge sys_clk_i);
    chk("status", {8'h00, e}, {8'h00, st});
  endtask
  task automatic sc;
    @(negedge sys_clk_i);
    sclr = 1'b1;
    @(negedge sys_clk_i);
    sclr = 1'b0;
  endtask
  task automatic pe(input logic [3:0] b, input logic g);
    @(negedge sys_clk_i);
    pe_req = 1'b1;
    pe_blk = b;
    #1 chk("pe_go", {15'h0000, g}, {15'h0000, grant});
    chk("pe_refused", {15'h0000, ~g}, {15'h0000, refused});
    @(negedge sys_clk_i);
    pe_req = 1'b0;
  endtask
  task automatic otp(input logic p, input logic [1:0] s, input logic [15:0] v);
    @(negedge sys_clk_i);
    {otp_prog, otp_lock, otp_sel, otp_d} = {p, ~p, s, v};
    @(negedge sys_clk_i);
    {otp_prog, otp_lock} = 2'b00;
    repeat (2) @(negedge sys_clk_i);
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk_i);
    errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    for (int b = 0; b < 16; b++) ls(b[3:0], 2'h1);
    ls(4'h3, 2'h0, 4'h1);
    pe(4'h3, 1'b0);
    stc(8'h82);
    sc();
    $display("reset and refusal done");
    blk = 4'($random(seed)) | 4'h8;
    flash_host_model_i.lock_cmd(blk, 8'hD0);
    ls(blk, 2'h0);
    pe(blk, 1'b1);
    flash_host_model_i.lock_cmd(blk, 8'h01);
    ls(blk, 2'h1);
    flash_host_model_i.lock_cmd(4'h3, 8'h2F);
    flash_host_model_i.lock_cmd(4'h5, 8'hD0);
    flash_host_model_i.lock_cmd(4'h5, 8'h2F);
    ls(4'h5, 2'h3);
    flash_host_model_i.lock_cmd(4'h5, 8'hD0);
    ls(4'h5, 2'h2);
    flash_host_model_i.lock_cmd(4'h6, 8'hD0);
    $display("lock commands done");
    wp_n = 1'b0;
    ls(4'h5, 2'h3);
    flash_host_model_i.lock_cmd(4'h3, 8'hD0);
    ls(4'h3, 2'h3);
    ls(4'h6, 2'h0);
    pe(4'h6, 1'b1);
    pe(4'h5, 1'b0);
    sc();
    wp_n = 1'b1;
    ls(4'h5, 2'h1 | 2'h2);
    flash_host_model_i.lock_cmd(4'h3, 8'hD0);
    ls(4'h3, 2'h2);
    flash_host_model_i.lock_cmd(4'h3, 8'h2F);
    ls(4'h3, 2'h3);
    $display("write protect done");
    psus = 1'b1;
    flash_host_model_i.lock_cmd(4'h6, 8'h01);
    ls(4'h6, 2'h0);
    stc(8'h84);
    psus = 1'b0;
    esus = 1'b1;
    stc(8'hC0);
    flash_host_model_i.lock_cmd(4'h6, 8'h2F);
    ls(4'h6, 2'h3);
    flash_host_model_i.lock_cmd(4'h6, 8'h90);
    stc(8'hF0);
    esus = 1'b0;
    stc(8'hB0);
    sc();
    $display("suspend and errors done");
    vpp_low = 1'b1;
    flash_host_model_i.lock_cmd(4'h7, 8'hD0);
    ls(4'h7, 2'h0);
    pe(4'h7, 1'b0);
    stc(8'h88);
    vpp_low = 1'b0;
    sc();
    $display("supply done");
    d = 16'($random(seed));
    otp(1'b1, 2'h1, d);
    chk("otp_word1", d, otp_val[95:80]);
    otp(1'b1, 2'h1, 16'hFFFF);
    chk("otp_word1", d, otp_val[95:80]);
    chk("otp_word0", 16'hFFFF, otp_val[79:64]);
    otp(1'b0, 2'h0, 16'hFFFF);
    chk("otp_locked", 16'h0001, {15'h0000, otp_lk});
    otp(1'b1, 2'h2, 16'h0000);
    chk("otp_word2", 16'hFFFF, otp_val[111:96]);
    stc(8'hB0);
    sc();
    $display("protection register done");
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    ls(4'h3, 2'h1);
    $display("second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
